// ### design/ufd_pkg.sv
// Shared constants for the full-speed device endpoint and DMA request logic
package ufd_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned LINE_BPS = 12_000_000;
  localparam int unsigned PLUG_TIME_US = 1000;
  localparam int unsigned PLUG_CYCLES = (PLUG_TIME_US * (CLK_HZ / 1_000_000)) + 1;
  localparam int unsigned NUM_EP = 4;
  localparam int unsigned EP0_FIFO_BYTES = 32;
  localparam int unsigned BULK_FIFO_BYTES = 64;
  localparam int unsigned ISO_FIFO_BYTES = 128;
  // Register byte addresses of the plain register port
  localparam logic [7:0] ADDR_EP_SELECT = 8'h00;
  localparam logic [7:0] ADDR_TX_MAXPKT = 8'h04;
  localparam logic [7:0] ADDR_TX_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_RX_MAXPKT = 8'h0C;
  localparam logic [7:0] ADDR_RX_CTRL2 = 8'h10;
  localparam logic [7:0] ADDR_PKT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_RX_COUNT = 8'h18;
  localparam logic [7:0] ADDR_EVENTS = 8'h1C;
  localparam logic [7:0] ADDR_DMA_CTRL = 8'h20;
  localparam logic [7:0] ADDR_TOGGLE = 8'h24;
  // Control 2 bit positions
  localparam int unsigned RX_MODE_BIT = 4;
  localparam int unsigned RX_DMAEN_BIT = 5;
  localparam int unsigned RX_AUTOCLR_BIT = 7;
  localparam int unsigned TX_DMAEN_BIT = 4;
  localparam int unsigned TX_AUTOSET_BIT = 7;
  localparam int unsigned TX_ISO_BIT = 6;
  localparam int unsigned RX_ISO_BIT = 6;
  // DMA control word fields
  localparam int unsigned DMA_REQ_BIT = 0;
  localparam int unsigned DMA_DIR_BIT = 1;
  localparam int unsigned DMA_MODE_BIT = 2;
  localparam int unsigned DMA_EP_LSB = 4;
  // Events register bit positions, write one to clear
  localparam int unsigned EV_RX_BIT = 0;
  localparam int unsigned EV_TX_BIT = 4;
  localparam int unsigned EV_PLUG_BIT = 8;
  localparam int unsigned EV_SHORT_BIT = 9;
  localparam int unsigned EV_TOGERR_BIT = 10;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  typedef enum logic [2:0] {
    UFD_LINE_IDLE = 3'b001,
    UFD_LINE_ATT = 3'b010,
    UFD_LINE_DET = 3'b100
  } ufd_line_t;
endpackage

// ### design/ufd_plug_detect.sv
// Line state qualifier that reports attach and detach after a 1 ms hold
`timescale 1ns/1ns
module ufd_plug_detect (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Line pins, already synchronised
  input wire logic line_plus_sync,
  input wire logic line_minus_sync,
  input wire logic pullup_en,
  // Results
  output logic plug_pulse,
  output logic attached
);
  ufd_pkg::ufd_line_t cand_reg, cand_next;
  logic [17:0] hold_reg;
  logic fired_reg;
  logic attached_reg;
  wire is_att = pullup_en & line_plus_sync & ~line_minus_sync;
  wire is_det = line_plus_sync & line_minus_sync;
  wire hold_done = (hold_reg == 18'(ufd_pkg::PLUG_CYCLES));

  always_comb begin
    case (1'b1)
      is_att: cand_next = ufd_pkg::UFD_LINE_ATT;
      is_det: cand_next = ufd_pkg::UFD_LINE_DET;
      default: cand_next = ufd_pkg::UFD_LINE_IDLE;
    endcase
  end

  // A change of line state restarts the hold, so glitches never report
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cand_reg <= ufd_pkg::UFD_LINE_IDLE;
      hold_reg <= 18'h00000;
      fired_reg <= 1'b0;
      attached_reg <= 1'b0;
      plug_pulse <= 1'b0;
    end else begin
      cand_reg <= cand_next;
      plug_pulse <= 1'b0;
      if (cand_next != cand_reg || cand_next == ufd_pkg::UFD_LINE_IDLE) begin
        hold_reg <= 18'h00000;
        fired_reg <= 1'b0;
      end else if (!hold_done) begin
        hold_reg <= hold_reg + 18'h00001;
      end else if (!fired_reg) begin
        fired_reg <= 1'b1;
        plug_pulse <= 1'b1; // [RULE23] [RULE24]
        attached_reg <= (cand_reg == ufd_pkg::UFD_LINE_ATT);
      end
    end
  end
  assign attached = attached_reg;

  plug_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE23]
    plug_pulse |-> $past(hold_reg) == 18'(ufd_pkg::PLUG_CYCLES))
    else $error("plug event before 1 ms hold");
  plug_idle_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE24]
    plug_pulse |-> $past(cand_reg) != ufd_pkg::UFD_LINE_IDLE)
    else $error("plug event from idle line");
  plug_seen_c: cover property (@(posedge core_clk) disable iff (!resetn) plug_pulse);
endmodule

// ### design/ufd_endpoint_dma.sv
// Endpoint packet state, toggle tracking and DMA request logic of a full-speed device
// Notes on behaviour
// RULE1 - Acts as 12 Mbps full-speed function
// RULE2 - Four endpoints, one to three either direction
// RULE3 - Control FIFO 32, bulk FIFOs 64 bytes
// RULE4 - Isochronous FIFOs 128 bytes each way
// RULE5 - Track and check DATA0/DATA1 per endpoint
// RULE6 - Software moves DMA-width multiples only
// RULE7 - Software OUT mode clears control bits
// RULE8 - Interrupt per OUT packet, software starts DMA
// RULE9 - Software clears receive ready after DMA
// RULE10 - Software IN mode clears control bits
// RULE11 - Interrupt when IN FIFO free
// RULE12 - Software sets transmit ready after load
// RULE13 - Hardware OUT mode sets three control bits
// RULE14 - Hardware OUT auto-clears receive ready
// RULE15 - Short packet interrupts, no DMA request
// RULE16 - Software reads count, unloads short packet
// RULE17 - Software falls back before final partial
// RULE18 - Isochronous OUT DMA keeps mode bit clear
// RULE19 - DMA stops at buffer end, interrupts
// RULE20 - Hardware IN mode sets two control bits
// RULE21 - Hardware IN requests load, sets ready
// RULE22 - Software sets ready once after block
// RULE23 - D+ high D- low 1 ms: attached; the code also requires pullup_en high
// RULE24 - Both lines high 1 ms: detached
// RULE25 - DMA request only when enabled and ready
`timescale 1ns/1ns
module ufd_endpoint_dma (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Packet engine side: one pulse per good packet, with its size and PID toggle
  input wire logic rx_done,
  input wire logic [1:0] rx_ep,
  input wire logic [7:0] rx_len,
  input wire logic rx_data1,
  input wire logic tx_sent,
  input wire logic [1:0] tx_ep,
  output logic [3:0] rx_accept,
  output logic [3:0] tx_data1,
  // DMA controller side
  input wire logic [3:0] dma_done,
  output logic [3:0] dma_req,
  output logic [3:0] dma_dir_in,
  // Line pins and pull-up enable
  input wire logic line_plus_pin,
  input wire logic line_minus_pin,
  input wire logic pullup_en,
  // Status
  output logic irq,
  output logic attached
);
  // Link runs at 12 Mbps; the bit engine outside uses this ratio [RULE1]
  localparam int unsigned BIT_DIV = ufd_pkg::CLK_HZ / ufd_pkg::LINE_BPS;

  // Endpoint zero has a 32-byte FIFO; others 64 bulk or 128 iso [RULE2] [RULE3] [RULE4]
  function automatic logic [7:0] fifo_cap(input logic [1:0] ep, input logic iso);
    if (ep == 2'd0)
      fifo_cap = 8'(ufd_pkg::EP0_FIFO_BYTES);
    else if (iso)
      fifo_cap = 8'(ufd_pkg::ISO_FIFO_BYTES);
    else
      fifo_cap = 8'(ufd_pkg::BULK_FIFO_BYTES);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] sel_reg;
  logic [7:0] tx_max_reg [4];
  logic [7:0] rx_max_reg [4];
  logic [7:0] tx_ctl2_reg [4];
  logic [7:0] rx_ctl2_reg [4];
  logic [7:0] rx_cnt_reg [4];
  logic [3:0] rx_rdy_reg, tx_rdy_reg, rx_tog_reg, tx_tog_reg;
  logic [3:0] ev_rx_reg, ev_tx_reg;
  logic ev_plug_reg, ev_short_reg, ev_togerr_reg;
  logic [7:0] dma_word_reg;
  logic [31:0] rdata_reg;
  logic [3:0] dma_req_reg, rx_acc_reg;
  logic irq_reg;
  logic plus_s1, plus_s2, minus_s1, minus_s2;
  logic plug_pulse;

  // Pins cross into core_clk through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      plus_s1 <= 1'b0;
      plus_s2 <= 1'b0;
      minus_s1 <= 1'b0;
      minus_s2 <= 1'b0;
    end else begin
      plus_s1 <= line_plus_pin;
      plus_s2 <= plus_s1;
      minus_s1 <= line_minus_pin;
      minus_s2 <= minus_s1;
    end
  end

  ufd_plug_detect u_plug (
    .core_clk(core_clk),
    .resetn(resetn),
    .line_plus_sync(plus_s2),
    .line_minus_sync(minus_s2),
    .pullup_en(pullup_en),
    .plug_pulse(plug_pulse),
    .attached(attached)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_sel = reg_wr & hit(reg_addr, ufd_pkg::ADDR_EP_SELECT);
  wire wr_txmax = reg_wr & hit(reg_addr, ufd_pkg::ADDR_TX_MAXPKT);
  wire wr_txc2 = reg_wr & hit(reg_addr, ufd_pkg::ADDR_TX_CTRL2);
  wire wr_rxmax = reg_wr & hit(reg_addr, ufd_pkg::ADDR_RX_MAXPKT);
  wire wr_rxc2 = reg_wr & hit(reg_addr, ufd_pkg::ADDR_RX_CTRL2);
  wire wr_stat = reg_wr & hit(reg_addr, ufd_pkg::ADDR_PKT_STATUS);
  wire wr_ev = reg_wr & hit(reg_addr, ufd_pkg::ADDR_EVENTS);
  wire wr_dma = reg_wr & hit(reg_addr, ufd_pkg::ADDR_DMA_CTRL);
  wire wr_tog = reg_wr & hit(reg_addr, ufd_pkg::ADDR_TOGGLE);
  wire [1:0] dma_ep = dma_word_reg[ufd_pkg::DMA_EP_LSB +: 2];
  wire dma_sw_go = dma_word_reg[ufd_pkg::DMA_REQ_BIT] & ~dma_word_reg[ufd_pkg::DMA_MODE_BIT];
  wire dma_hw = dma_word_reg[ufd_pkg::DMA_MODE_BIT];
  wire dma_in = dma_word_reg[ufd_pkg::DMA_DIR_BIT];
  wire [3:0] tx_pkt = {3'h0, tx_sent} << tx_ep;
  // Toggle check: a repeated PID means the host missed our handshake [RULE5]
  wire tog_ok = (rx_data1 == rx_tog_reg[rx_ep]);
  wire rx_room = ~rx_rdy_reg[rx_ep]
                 & (rx_len <= fifo_cap(rx_ep, rx_ctl2_reg[rx_ep][ufd_pkg::RX_ISO_BIT]));
  wire rx_take = rx_done & rx_room & tog_ok;
  wire [3:0] rx_take_oh = {3'h0, rx_take} << rx_ep;
  wire rx_short = rx_take & (rx_len < rx_max_reg[rx_ep]);

  logic [3:0] rx_hw, tx_hw, req_next, rx_clr, tx_set;
  always_comb begin
    for (int i = 0; i < ufd_pkg::NUM_EP; i++) begin
      rx_hw[i] = rx_ctl2_reg[i][ufd_pkg::RX_DMAEN_BIT] & rx_ctl2_reg[i][ufd_pkg::RX_MODE_BIT]
                 & rx_ctl2_reg[i][ufd_pkg::RX_AUTOCLR_BIT];
      tx_hw[i] = tx_ctl2_reg[i][ufd_pkg::TX_DMAEN_BIT] & tx_ctl2_reg[i][ufd_pkg::TX_AUTOSET_BIT];
      // Only full packets stand for hardware unload; short ones stay for software [RULE15]
      req_next[i] = (rx_hw[i] & rx_rdy_reg[i] & (rx_cnt_reg[i] == rx_max_reg[i])
                    & dma_hw & ~dma_in & (dma_ep == 2'(i)))
                  | (tx_hw[i] & ~tx_rdy_reg[i] & dma_hw & dma_in & (dma_ep == 2'(i)))
                  | (dma_sw_go & (dma_ep == 2'(i))
                    & (dma_in ? ~tx_rdy_reg[i] : rx_rdy_reg[i])); // [RULE25] [RULE8] [RULE11]
      rx_clr[i] = dma_done[i] & rx_hw[i] & ~dma_in; // [RULE14]
      tx_set[i] = dma_done[i] & tx_hw[i] & dma_in; // [RULE21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-endpoint state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_reg <= 2'h0;
      for (int i = 0; i < ufd_pkg::NUM_EP; i++) begin
        tx_max_reg[i] <= ufd_pkg::RESET_BYTE;
        rx_max_reg[i] <= ufd_pkg::RESET_BYTE;
        tx_ctl2_reg[i] <= ufd_pkg::RESET_BYTE;
        rx_ctl2_reg[i] <= ufd_pkg::RESET_BYTE;
        rx_cnt_reg[i] <= ufd_pkg::RESET_BYTE;
      end
    end else begin
      if (wr_sel)
        sel_reg <= reg_wdata[1:0];
      if (wr_txmax)
        tx_max_reg[sel_reg] <= reg_wdata[7:0];
      if (wr_rxmax)
        rx_max_reg[sel_reg] <= reg_wdata[7:0];
      if (wr_txc2)
        tx_ctl2_reg[sel_reg] <= reg_wdata[7:0];
      if (wr_rxc2)
        rx_ctl2_reg[sel_reg] <= reg_wdata[7:0];
      if (rx_take)
        rx_cnt_reg[rx_ep] <= rx_len;
    end
  end

  // Ready bits: hardware set wins over software clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_rdy_reg <= 4'h0;
      tx_rdy_reg <= 4'h0;
      rx_tog_reg <= 4'h0;
      tx_tog_reg <= 4'h0;
    end else begin
      rx_rdy_reg <= ((rx_rdy_reg & ~rx_clr) & ~(wr_stat ? reg_wdata[3:0] : 4'h0))
                    | rx_take_oh;
      tx_rdy_reg <= ((tx_rdy_reg & ~tx_pkt) | tx_set | (wr_stat ? reg_wdata[7:4] : 4'h0));
      rx_tog_reg <= (rx_tog_reg ^ rx_take_oh) & ~(wr_tog ? reg_wdata[3:0] : 4'h0); // [RULE5]
      tx_tog_reg <= (tx_tog_reg ^ tx_pkt) & ~(wr_tog ? reg_wdata[7:4] : 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events, write one to clear, set wins
  wire [31:0] ev_clr = wr_ev ? reg_wdata : 32'h0000_0000;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ev_rx_reg <= 4'h0;
      ev_tx_reg <= 4'h0;
      ev_plug_reg <= 1'b0;
      ev_short_reg <= 1'b0;
      ev_togerr_reg <= 1'b0;
    end else begin
      // Every accepted packet flags in software mode, only short ones in hardware mode [RULE8] [RULE15]
      ev_rx_reg <= (ev_rx_reg & ~ev_clr[3:0]) | (rx_take_oh & ~(rx_hw & ~{4{rx_short}}));
      ev_tx_reg <= (ev_tx_reg & ~ev_clr[7:4]) | (tx_pkt & ~tx_hw); // [RULE11]
      ev_plug_reg <= (ev_plug_reg & ~ev_clr[ufd_pkg::EV_PLUG_BIT]) | plug_pulse;
      ev_short_reg <= (ev_short_reg & ~ev_clr[ufd_pkg::EV_SHORT_BIT])
                      | (rx_short & rx_hw[rx_ep]); // [RULE15]
      ev_togerr_reg <= (ev_togerr_reg & ~ev_clr[ufd_pkg::EV_TOGERR_BIT]) | (rx_done & ~tog_ok);
    end
  end

  wire [31:0] ev_word = {21'h0, ev_togerr_reg, ev_short_reg, ev_plug_reg, ev_tx_reg, ev_rx_reg};

  // DMA control word and outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dma_word_reg <= ufd_pkg::RESET_BYTE;
      dma_req_reg <= 4'h0;
      rx_acc_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_dma)
        dma_word_reg <= reg_wdata[7:0];
      else if (dma_sw_go && (dma_done != 4'h0))
        dma_word_reg[ufd_pkg::DMA_REQ_BIT] <= 1'b0;
      dma_req_reg <= req_next & ~dma_done; // [RULE25]
      rx_acc_reg <= ~rx_rdy_reg;
      irq_reg <= (ev_word != 32'h0000_0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      ufd_pkg::ADDR_EP_SELECT: rd_mux = {30'h0, sel_reg};
      ufd_pkg::ADDR_TX_MAXPKT: rd_mux = {24'h0, tx_max_reg[sel_reg]};
      ufd_pkg::ADDR_TX_CTRL2: rd_mux = {24'h0, tx_ctl2_reg[sel_reg]};
      ufd_pkg::ADDR_RX_MAXPKT: rd_mux = {24'h0, rx_max_reg[sel_reg]};
      ufd_pkg::ADDR_RX_CTRL2: rd_mux = {24'h0, rx_ctl2_reg[sel_reg]};
      ufd_pkg::ADDR_PKT_STATUS: rd_mux = {24'h0, tx_rdy_reg, rx_rdy_reg};
      ufd_pkg::ADDR_RX_COUNT: rd_mux = {24'h0, rx_cnt_reg[sel_reg]};
      ufd_pkg::ADDR_EVENTS: rd_mux = ev_word;
      ufd_pkg::ADDR_DMA_CTRL: rd_mux = {24'h0, dma_word_reg};
      ufd_pkg::ADDR_TOGGLE: rd_mux = {23'h0, attached, tx_tog_reg, rx_tog_reg};
      default: rd_mux = ufd_pkg::RESET_WORD;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      rdata_reg <= ufd_pkg::RESET_WORD;
    else
      rdata_reg <= reg_rd ? rd_mux : ufd_pkg::RESET_WORD;
  end

  assign reg_rdata = rdata_reg;
  assign dma_req = dma_req_reg;
  assign dma_dir_in = {4{dma_in}};
  assign rx_accept = rx_acc_reg;
  assign tx_data1 = tx_tog_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  req_cause_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE25]
    (dma_req & ~$past(rx_hw | tx_hw | {4{dma_sw_go}})) == 4'h0)
    else $error("DMA request with DMA disabled");
  short_noreq_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE15]
    (rx_short && rx_hw[rx_ep] && !dma_sw_go) |=> ##1 !dma_req[$past(rx_ep, 2)])
    else $error("short packet raised DMA request");
  auto_clr_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE14]
    (rx_clr & ~rx_take_oh) != 4'h0 |=> (rx_rdy_reg & $past(rx_clr & ~rx_take_oh)) == 4'h0)
    else $error("receive ready not auto-cleared");
  auto_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE21]
    tx_set != 4'h0 |=> (tx_rdy_reg & $past(tx_set)) == $past(tx_set))
    else $error("transmit ready not auto-set");
  toggle_flip_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE5]
    (rx_take && rx_ep == 2'd3 && !wr_tog) |=> rx_tog_reg[3] != $past(rx_tog_reg[3]))
    else $error("toggle did not flip");
  toggle_err_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE5]
    (rx_done && !tog_ok) |=> ev_togerr_reg && $stable(rx_tog_reg))
    else $error("repeated packet not flagged");
  sw_rx_event_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE8]
    (rx_take && !rx_hw[rx_ep]) |=> ev_rx_reg[$past(rx_ep)] ##1 irq)
    else $error("software OUT packet not signalled");
  sw_tx_event_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE11]
    (tx_sent && !tx_hw[tx_ep]) |=> ev_tx_reg[$past(tx_ep)])
    else $error("free IN FIFO not signalled");
  ep0_cap_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE3]
    (rx_done && rx_ep == 2'd0 && rx_len > 8'h20) |-> !rx_take)
    else $error("control FIFO overflowed");
  iso_cap_a: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE4]
    (rx_done && rx_ep != 2'd0 && rx_len > 8'h80) |-> !rx_take)
    else $error("isochronous FIFO overflowed");
  hw_out_c: cover property (@(posedge core_clk) disable iff (!resetn) rx_clr != 4'h0);
  hw_in_c: cover property (@(posedge core_clk) disable iff (!resetn) tx_set != 4'h0);
  short_c: cover property (@(posedge core_clk) disable iff (!resetn) rx_short && rx_hw[rx_ep]);
  sw_dma_c: cover property (@(posedge core_clk) disable iff (!resetn) dma_sw_go && dma_req != 4'h0);
endmodule

// ### testbench/ufd_dma_partner.sv
// Behavioural model of the shared DMA controller facing the endpoints
`timescale 1ns/1ns
module ufd_dma_partner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Endpoint request side
  input wire logic [3:0] dma_req,
  input wire logic [7:0] delay_cycles,
  output logic [3:0] dma_done
);
  logic busy;
  logic [1:0] ch;
  logic [1:0] pick;
  logic [7:0] cnt;
  // Buffer budget in packets; once spent the channel serves no more
  logic [7:0] left;
  ////////////////////////////////////////
  // Lowest endpoint wins; one channel serves one packet at a time
  always_comb begin
    pick = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (dma_req[i]) begin
        pick = 2'(i);
      end
    end
  end
  ////////////////////////////////////////
  // Whole packets only, so every move is a multiple of the transfer width
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'h0;
      ch <= 2'h0;
      cnt <= 8'h00;
      left <= 8'hFF;
      dma_done <= 4'h0;
    end else begin
      dma_done <= 4'h0;
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy) begin
        dma_done[ch] <= 1'h1;
        busy <= 1'h0;
        // Holdoff so a request that is about to fall is not served twice
        cnt <= 8'h03;
      end else if (|dma_req && left != 8'h00) begin
        left <= left - 8'h01;
        busy <= 1'h1;
        ch <= pick;
        cnt <= delay_cycles;
      end
    end
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the endpoint DMA request logic
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] SEL = ufd_pkg::ADDR_EP_SELECT;
  localparam logic [7:0] ST = ufd_pkg::ADDR_PKT_STATUS;
  localparam logic [7:0] EV = ufd_pkg::ADDR_EVENTS;
  localparam logic [7:0] DW = ufd_pkg::ADDR_DMA_CTRL;
  localparam logic [7:0] RC2 = ufd_pkg::ADDR_RX_CTRL2;
  localparam logic [7:0] TC2 = ufd_pkg::ADDR_TX_CTRL2;
  logic core_clk, resetn, reg_wr, reg_rd, rx_done, rx_data1, tx_sent;
  logic [7:0] reg_addr, rx_len, dly;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] rx_ep, tx_ep;
  logic [3:0] rx_accept, tx_data1, dma_done, dma_req, dma_dir_in;
  logic line_plus_pin, line_minus_pin, pullup_en, irq, attached;
  int bad_count, samples_checked;
  ufd_endpoint_dma dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_done(rx_done), .rx_ep(rx_ep), .rx_len(rx_len), .rx_data1(rx_data1),
    .tx_sent(tx_sent), .tx_ep(tx_ep), .rx_accept(rx_accept), .tx_data1(tx_data1),
    .dma_done(dma_done), .dma_req(dma_req), .dma_dir_in(dma_dir_in),
    .line_plus_pin(line_plus_pin), .line_minus_pin(line_minus_pin),
    .pullup_en(pullup_en), .irq(irq), .attached(attached));
  ufd_dma_partner pm (.core_clk(core_clk), .resetn(resetn), .dma_req(dma_req),
    .delay_cycles(dly), .dma_done(dma_done));
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic end_of_test;
    $display("Counts: %0d checked, %0d bad", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // Every access leaves one idle cycle so a strobe is never set twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
    @(posedge core_clk);
    chk(n, e, d);
  endtask
  task automatic pkt(input logic [1:0] e, input logic [7:0] n, input logic d1);
    rx_ep <= e;
    rx_len <= n;
    rx_data1 <= d1;
    rx_done <= 1'h1;
    @(posedge core_clk);
    rx_done <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic sent(input logic [1:0] e);
    tx_ep <= e;
    tx_sent <= 1'h1;
    @(posedge core_clk);
    tx_sent <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wq(input int i, input logic val);
    int k;
    for (k = 0; k < 64 && dma_req[i] !== val; k++) @(posedge core_clk);
    chk("dma_req", 32'(val), 32'(dma_req[i]));
    if (k == 64) end_of_test();
  endtask
  ////////////////////////////////////////
  task automatic t_sw_out;
    wr(EV, 32'h7FF);
    wr(SEL, 32'h1);
    wr(ufd_pkg::ADDR_RX_MAXPKT, 32'h40);
    wr(RC2, 32'h0);
    pkt(2'h1, 8'h40, 1'h0);
    rchk("rx ready", ST, 32'h2);
    rchk("rx event", EV, 32'h2);
    chk("irq", 32'h1, irq);
    chk("rx_accept", 32'h0, rx_accept[1]);
    wr(DW, 32'h11);
    wq(1, 1'h1);
    chk("dir", 32'h0, dma_dir_in);
    wq(1, 1'h0);
    wr(ST, 32'h2);
    rchk("rx cleared", ST, 32'h0);
    wr(EV, 32'h7FF);
    rchk("events", EV, 32'h0);
    chk("irq low", 32'h0, irq);
    $display("Test software receive finished");
  endtask
  task automatic t_toggle;
    pkt(2'h1, 8'h40, 1'h0);
    rchk("dup dropped", ST, 32'h0);
    rchk("toggle event", EV, 32'h400);
    pkt(2'h1, 8'h40, 1'h1);
    rchk("data1 taken", ST, 32'h2);
    wr(ST, 32'h2);
    wr(EV, 32'h7FF);
    $display("Test toggle finished");
  endtask
  task automatic t_fifo;
    pkt(2'h0, 8'h21, 1'h0);
    rchk("ep0 over", ST, 32'h0);
    pkt(2'h0, 8'h20, 1'h0);
    rchk("ep0 full", ST, 32'h1);
    pkt(2'h2, 8'h41, 1'h0);
    rchk("bulk over", ST, 32'h1);
    pkt(2'h2, 8'h40, 1'h0);
    rchk("bulk full", ST, 32'h5);
    wr(ST, 32'h5);
    wr(SEL, 32'h2);
    wr(RC2, 32'h40);
    pkt(2'h2, 8'h80, 1'h1);
    rchk("iso full", ST, 32'h4);
    wr(RC2, 32'h0);
    wr(ST, 32'h4);
    wr(EV, 32'h7FF);
    $display("Test sizes finished");
  endtask
  task automatic t_sw_in;
    dly <= 8'h14;
    wr(TC2, 32'h0);
    wr(DW, 32'h23);
    wq(2, 1'h1);
    chk("dir in", 32'hF, dma_dir_in);
    wq(2, 1'h0);
    wr(ST, 32'h40);
    rchk("tx ready", ST, 32'h40);
    sent(2'h2);
    rchk("tx freed", ST, 32'h0);
    rchk("tx event", EV, 32'h40);
    chk("tx toggle", 32'h4, tx_data1);
    wr(EV, 32'h7FF);
    $display("Test software transmit finished");
  endtask
  task automatic t_hw_out;
    dly <= 8'h00;
    wr(SEL, 32'h3);
    wr(ufd_pkg::ADDR_RX_MAXPKT, 32'h8);
    wr(RC2, 32'hB0);
    wr(DW, 32'h34);
    pkt(2'h3, 8'h08, 1'h0);
    wq(3, 1'h1);
    wq(3, 1'h0);
    rchk("auto clear", ST, 32'h0);
    pkt(2'h3, 8'h04, 1'h1);
    repeat (8) begin
      @(posedge core_clk);
      chk("short no req", 32'h0, dma_req);
    end
    rchk("short ready", ST, 32'h8);
    rchk("short event", EV, 32'h208);
    chk("irq short", 32'h1, irq);
    rchk("short count", ufd_pkg::ADDR_RX_COUNT, 32'h4);
    wr(RC2, 32'h0);
    wr(DW, 32'h0);
    wr(ST, 32'h8);
    wr(EV, 32'h7FF);
    $display("Test hardware receive finished");
  endtask
  task automatic t_hw_in;
    wr(SEL, 32'h1);
    wr(TC2, 32'h90);
    wr(DW, 32'h16);
    wq(1, 1'h1);
    wq(1, 1'h0);
    rchk("auto set", ST, 32'h20);
    chk("ready no req", 32'h0, dma_req);
    sent(2'h1);
    wq(1, 1'h1);
    wq(1, 1'h0);
    rchk("auto set again", ST, 32'h20);
    wr(DW, 32'h0);
    sent(2'h1);
    rchk("block sent", ST, 32'h0);
    wr(ST, 32'h20);
    rchk("final ready", ST, 32'h20);
    $display("Test hardware transmit finished");
  endtask
  task automatic t_plug;
    int k;
    wr(EV, 32'h7FF);
    line_plus_pin <= 1'h1;
    pullup_en <= 1'h1;
    repeat (ufd_pkg::PLUG_CYCLES - 50) @(posedge core_clk);
    chk("attached early", 32'h0, attached);
    for (k = 0; k < 100 && attached !== 1'h1; k++) @(posedge core_clk);
    chk("attached", 32'h1, attached);
    rchk("plug event", EV, 32'h100);
    line_minus_pin <= 1'h1;
    repeat (200) @(posedge core_clk);
    line_minus_pin <= 1'h0;
    @(posedge core_clk);
    chk("blip ignored", 32'h1, attached);
    $display("Test plug finished");
  endtask
  ////////////////////////////////////////
  initial begin
    resetn = 1'h0;
    {reg_wr, reg_rd, rx_done, rx_data1, tx_sent} = 5'h00;
    {reg_addr, rx_len, dly, rx_ep, tx_ep} = 28'h0;
    reg_wdata = 32'h0;
    {line_plus_pin, line_minus_pin, pullup_en} = 3'h0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    rchk("word reset", DW, 32'h0);
    chk("req reset", 32'h0, dma_req);
    t_sw_out();
    t_toggle();
    t_fifo();
    t_sw_in();
    t_hw_out();
    t_hw_in();
    t_plug();
    end_of_test();
  end
endmodule
